// [dv/sswp_chk.sv]
// link checker for the status block: watches the spi wires between both ends
// assumes mode 0 link and a host half period of four aclk cycles
`timescale 1ns/1ps
module sswp_chk
   import sswp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   logic       sclk_q;
   logic [5:0] rises_q;
   logic [7:0] op_q;
   logic       rise;

   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   // sclk edge seen in the aclk domain
   assign rise = sclk & ~sclk_q;

   // rise count per frame, cleared while deselected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_q  <= 1'b0;
         rises_q <= 6'h00;
      end else begin
         sclk_q <= sclk;
         if (cs_n) rises_q <= 6'h00;
         else if (rise) rises_q <= rises_q + 6'h01;
      end
   end

   // opcode capture, first eight rises only
   always_ff @(posedge aclk) begin
      if (!aresetn) op_q <= 8'h00;
      else if (!cs_n && rise && rises_q < 6'h08) op_q <= {op_q[6:0], mosi};
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_OE_IDLE: assert property (cs_n [*6] |-> !miso_oe)
      else $error("miso driven while deselected");
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("sclk high outside a frame");
   AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("sclk high phase not four cycles");
   AST_MOSI_HOLD: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("mosi moved while sclk high");
   AST_CS_FALL: assert property ($fell(cs_n) |-> !sclk)
      else $error("frame opened with sclk high");
   AST_CS_RISE: assert property ($rose(cs_n) |-> !$past(sclk))
      else $error("frame closed with sclk high");
   AST_FRAME_LEN: assert property ($rose(cs_n) |-> rises_q inside {6'd8, 6'd16, 6'd24})
      else $error("frame not whole bytes");
   AST_READ_DRIVE: assert property (rise && !cs_n && ((op_q == OP_STATUS_READ &&
      rises_q == 6'd9) || (op_q == OP_STATUS_FASTREAD && rises_q == 6'd17)) |-> miso_oe)
      else $error("status byte not driven");
   AST_MISO_SETTLED: assert property ($fell(sclk) && !cs_n && miso_oe |-> $stable(miso))
      else $error("miso moved at the host sampling edge");
endmodule // sswp_chk

// [dv/sswp_tb.sv]
// testbench for the status block: host over axi4-lite, device on the far end
// assumes both ends joined by one link interface, checker beside it
`timescale 1ns/1ps
module sswp_tb;
   import sswp_pkg::*;
   logic        aclk = 0, aresetn = 0;
   logic [7:0]  awaddr = 0, araddr = 0, g, d, nv_status = 0, nv_out, st_out;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, v;
   logic        awready, wready, bvalid, arready, rvalid, cprot, swok;
   logic [1:0]  bresp, rresp, r, b;
   logic        pin_n = 1, sv_busy = 0, rc_busy = 0, sv_done = 0, nv_load = 0;
   logic [14:0] caddr = 0;
   logic [7:0]  exp_st = 0;
   logic [7:0]  wops [7] = '{OP_MEM_WRITE, OP_CLOCK_WRITE, OP_SERIAL_WRITE, OP_SAVE,
                             OP_RESTORE, OP_AUTOSAVE_ON, OP_AUTOSAVE_OFF};
   logic [14:0] cor [4] = '{15'h5FFF, 15'h6000, 15'h3FFF, 15'h7FFF};
   int          n_errors = 0, total_checks = 0, cyc = 0;

   // ----------------------------------------
   // ends, link and checker
   // ----------------------------------------
   sswp_link_if sswp_link_if_i ();
   sswp_host #(.DIV(HOST_DIV)) sswp_host_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(sswp_link_if_i));
   sswp_device sswp_device_i (.aclk(aclk), .aresetn(aresetn), .link(sswp_link_if_i),
      .protect_pin_n(pin_n), .save_busy(sv_busy), .restore_busy(rc_busy),
      .save_done(sv_done), .nv_status(nv_status), .nv_load(nv_load), .check_addr(caddr),
      .check_protected(cprot), .serial_write_ok(swok), .nv_status_out(nv_out),
      .status_out(st_out));
   sswp_chk sswp_chk_i (.aclk(aclk), .aresetn(aresetn), .sclk(sswp_link_if_i.sclk),
      .cs_n(sswp_link_if_i.cs_n), .mosi(sswp_link_if_i.mosi), .miso(sswp_link_if_i.miso),
      .miso_oe(sswp_link_if_i.miso_oe));

   // clock, and a cycle ceiling well above the expected run
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 100000) begin
         n_errors++;
         finish_test();
      end
   end

   // ----------------------------------------
   // expectations and compares
   // ----------------------------------------
   // lock only ever sets; busy and latch untouched by data
   function automatic logic [7:0] wr_exp(input logic [7:0] o, input logic [7:0] x,
                                         input logic blk);
      return blk ? (o & 8'hFD) : (((o & 8'h41) | (x & 8'hCC)) & 8'hFD);
   endfunction
   function automatic logic prot_exp(input logic [1:0] s, input logic [14:0] a);
      return (s == 2'b11) || (s == 2'b10 && a >= 15'h4000) || (s == 2'b01 && a >= 15'h6000);
   endfunction
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", nm, e, s);
      end
   endtask

   // ----------------------------------------
   // bus and link tasks
   // ----------------------------------------
   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a; awvalid <= 1; wdata <= x; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      x = rdata; rs = rresp;
      rready <= 0;
   endtask
   // one frame: go, then poll busy low
   task automatic spi(input logic [7:0] op, input logic [7:0] x, output logic [7:0] res);
      logic [1:0]  rs;
      logic [31:0] p;
      int          k;
      axi_wr(REG_CMD, {15'h0, 1'b1, x, op}, rs);
      chk_byte("cmd resp", {6'h0, RESP_OKAY}, {6'h0, rs});
      p = 32'h100;
      k = 0;
      while (p[8] !== 1'b0 && k < 200) begin
         axi_rd(REG_RESULT, p, rs);
         k++;
      end
      chk_bit("frame done", 1'b0, p[8]);
      res = p[7:0];
   endtask
   task automatic rd_st(input logic fast);
      logic [7:0] s;
      spi(fast ? OP_STATUS_FASTREAD : OP_STATUS_READ, 8'h00, s);
      chk_byte("status", exp_st, s);
      chk_byte("status_out", exp_st, st_out);
   endtask
   // blocked writes are followed by a latch clear so the latch is known
   task automatic wr_st(input logic [7:0] x, input logic blk);
      logic [7:0] s;
      spi(OP_LATCH_SET, 8'h00, s);
      spi(OP_STATUS_WRITE, x, s);
      exp_st = wr_exp(exp_st, x, blk);
      if (blk) spi(OP_LATCH_CLEAR, 8'h00, s);
      rd_st(x[0]);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(52722));
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      rd_st(0);
      spi(OP_STATUS_WRITE, 8'hFF, g);
      rd_st(1);
      spi(OP_LATCH_SET, 8'h00, g);
      exp_st[1] = 1;
      rd_st(0);
      chk_bit("serial ok", 1'b1, swok);
      spi(OP_LATCH_CLEAR, 8'h00, g);
      exp_st[1] = 0;
      rd_st(0);
      foreach (wops[i]) begin
         spi(OP_LATCH_SET, 8'h00, g);
         spi(wops[i], 8'h00, g);
         rd_st(0);
      end
      // random status data with the lock kept clear, busy sources random
      for (int i = 0; i < 12; i++) begin
         d = 8'($urandom);
         d[6] = 0;
         b = 2'($urandom);
         sv_busy <= b[0];
         rc_busy <= b[1];
         exp_st[0] = |b;
         wr_st(d, 0);
         caddr <= ($urandom % 2) ? cor[$urandom % 4] : 15'($urandom);
         sv_done <= 1;
         @(posedge aclk);
         sv_done <= 0;
         @(posedge aclk);
         chk_bit("protected", prot_exp(exp_st[3:2], caddr), cprot);
         chk_byte("nv copy", exp_st & 8'hCC, nv_out);
      end
      sv_busy <= 0;
      rc_busy <= 0;
      exp_st[0] = 0;
      wr_st(8'h80, 0);
      pin_n <= 0;
      wr_st(8'h0C, 1);
      pin_n <= 1;
      wr_st(8'h0C, 0);
      pin_n <= 0;
      wr_st(8'h88, 0);
      pin_n <= 1;
      wr_st(8'h40, 0);
      spi(OP_LATCH_SET, 8'h00, g);
      chk_bit("serial ok", 1'b0, swok);
      spi(OP_LATCH_CLEAR, 8'h00, g);
      wr_st(8'h00, 0);
      // restoring saved fields must never undo the lock
      nv_status <= 8'h8C;
      nv_load <= 1;
      @(posedge aclk);
      nv_load <= 0;
      exp_st = 8'hCC;
      rd_st(0);
      axi_rd(8'h10, v, r);
      chk_byte("unmapped resp", {6'h0, RESP_SLVERR}, {6'h0, r});
      finish_test();
   end
endmodule // sswp_tb

// [hw/sswp_device.sv]
// status register and write-protect logic of the memory device end
// assumes sclk, cs_n and mosi come from another domain; save/restore engine outside
//
// Functional notes
// - busy bit 0 high during save/restore
// - status write alters only bits 2,3,6,7
// - bits 4 and 5 read zero always
// - serial writes allowed until lock bit set
// - lock bit set once, never cleared
// - latch bit 1, cleared at power-up
// - latch-set opcode sets the latch
// - latch low ignores write-class commands
// - write-class completion clears the latch
// - latch-clear acts at cs rising edge
// - status read shifts out status byte
// - fast read returns status after dummy
// - host sends opcode then eight data bits
// - protect select decodes quarter, half, all
// - writes into protected segment discarded
// - pin guard enable gates protect pin
// - status values volatile until save copies
// - host saves after status change if needed
// - shipped status fields all read zero
// - latch-set 06h, latch-clear 04h opcodes
// - read 05h, fast read 09h, write 01h
// - msb first, start on cs falling
// - pin low plus guard blocks status writes
`timescale 1ns/1ps
module sswp_device
   import sswp_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   sswp_link_if.device      link,
   input  wire logic        protect_pin_n,
   input  wire logic        save_busy,
   input  wire logic        restore_busy,
   input  wire logic        save_done,
   input  wire logic [7:0]  nv_status,
   input  wire logic        nv_load,
   input  wire logic [14:0] check_addr,
   output logic             check_protected,
   output logic             serial_write_ok,
   output logic [7:0]       nv_status_out,
   output logic [7:0]       status_out
);
   // ------------------------------------------------------------
   // pin synchronisers, three stages, change once stages 2 and 3 agree
   // ------------------------------------------------------------
   logic [2:0] sclk_s_q, cs_s_q, mosi_s_q;
   logic       sclk_q, cs_n_q, mosi_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_s_q <= 3'h0;
         cs_s_q   <= 3'h7;
         mosi_s_q <= 3'h0;
         sclk_q   <= 1'b0;
         cs_n_q   <= 1'b1;
         mosi_q   <= 1'b0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], link.sclk};
         cs_s_q   <= {cs_s_q[1:0], link.cs_n};
         mosi_s_q <= {mosi_s_q[1:0], link.mosi};
         if (sclk_s_q[1] == sclk_s_q[2]) sclk_q <= sclk_s_q[2];
         if (cs_s_q[1] == cs_s_q[2]) cs_n_q <= cs_s_q[2];
         if (mosi_s_q[1] == mosi_s_q[2]) mosi_q <= mosi_s_q[2];
      end
   end

   // protect pin through the same three-stage filter; idle level is unprotected
   logic [2:0] pin_s_q;
   logic       pin_n_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s_q <= 3'h7;
         pin_n_q <= 1'b1;
      end else begin
         pin_s_q <= {pin_s_q[1:0], protect_pin_n};
         if (pin_s_q[1] == pin_s_q[2]) pin_n_q <= pin_s_q[2];
      end
   end

   // filtered levels and their edges
   logic sclk_f, cs_f, sclk_prev_q, cs_prev_q;
   assign sclk_f = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_q;
   assign cs_f   = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_n_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_f;
         cs_prev_q   <= cs_f;
      end
   end
   logic sclk_rise, sclk_fall, cs_fall, cs_rise;
   assign sclk_rise = sclk_f & ~sclk_prev_q & ~cs_f;
   assign sclk_fall = ~sclk_f & sclk_prev_q & ~cs_f;
   assign cs_fall   = ~cs_f & cs_prev_q;
   assign cs_rise   = cs_f & ~cs_prev_q;

   // ------------------------------------------------------------
   // frame shifter, msb first
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SSWP_IDLE   = 3'b000,
      SSWP_OPCODE = 3'b001,
      SSWP_DUMMY  = 3'b010,
      SSWP_SEND   = 3'b011,
      SSWP_DATA   = 3'b100,
      SSWP_HOLD   = 3'b101
   } sswp_state_type;
   sswp_state_type state_q;
   logic [7:0] shift_q, out_q;
   logic [2:0] bit_q;
   logic       byte_done;
   logic [7:0] rx_byte;
   assign byte_done = sclk_rise && bit_q == 3'd7;
   assign rx_byte   = {shift_q[6:0], mosi_q};

   // ------------------------------------------------------------
   // status register fields
   // ------------------------------------------------------------
   logic       latch_q, clear_at_end_q, wr_done_q;
   logic [1:0] sel_q;
   logic       lock_q, guard_q;
   logic [7:0] status_rd;
   assign status_rd = {guard_q, lock_q, 2'b00, sel_q, latch_q,
                       save_busy | restore_busy};
   assign status_out = status_rd;

   // write-class opcodes need the latch
   function automatic logic is_write_class(input logic [7:0] op);
      return op inside {OP_STATUS_WRITE, OP_MEM_WRITE, OP_CLOCK_WRITE, OP_SERIAL_WRITE,
                        OP_SAVE, OP_RESTORE, OP_AUTOSAVE_ON, OP_AUTOSAVE_OFF};
   endfunction

   // command decode and shift state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q  <= SSWP_IDLE;
         shift_q  <= 8'h00;
         bit_q    <= 3'd0;
      end else if (cs_f) begin
         state_q <= SSWP_IDLE;
         bit_q   <= 3'd0;
      end else begin
         if (cs_fall) begin
            state_q <= SSWP_OPCODE;
            bit_q   <= 3'd0;
         end
         if (sclk_rise) begin
            shift_q <= rx_byte;
            bit_q   <= bit_q + 3'd1;
         end
         if (byte_done) begin
            unique case (state_q)
               SSWP_OPCODE: begin
                  if (rx_byte == OP_STATUS_READ) state_q <= SSWP_SEND;
                  else if (rx_byte == OP_STATUS_FASTREAD) state_q <= SSWP_DUMMY;
                  else if (rx_byte == OP_STATUS_WRITE && latch_q) state_q <= SSWP_DATA;
                  else state_q <= SSWP_HOLD;  // rejected until cs rises
               end
               SSWP_DUMMY: state_q <= SSWP_SEND;
               SSWP_SEND:  state_q <= SSWP_SEND;  // status repeats while clocked
               SSWP_DATA:  state_q <= SSWP_HOLD;
               SSWP_IDLE, SSWP_HOLD: state_q <= state_q;
            endcase
         end
      end
   end

   // status write, lock and pin guard
   logic status_locked, wr_fire;
   assign status_locked = guard_q & ~pin_n_q;
   assign wr_fire = byte_done && state_q == SSWP_DATA && !status_locked;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_q   <= STATUS_RESET[BIT_SEL_HI:BIT_SEL_LO];
         lock_q  <= STATUS_RESET[BIT_LOCK];
         guard_q <= STATUS_RESET[BIT_PIN_GUARD];
      end else if (nv_load) begin
         sel_q   <= nv_status[BIT_SEL_HI:BIT_SEL_LO];
         lock_q  <= lock_q | nv_status[BIT_LOCK];
         guard_q <= nv_status[BIT_PIN_GUARD];
      end else if (wr_fire) begin
         sel_q   <= rx_byte[BIT_SEL_HI:BIT_SEL_LO];
         lock_q  <= lock_q | rx_byte[BIT_LOCK];
         guard_q <= rx_byte[BIT_PIN_GUARD];
      end
   end

   // latch: set on latch-set opcode, cleared at cs rise for clear/write-class
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_q        <= 1'b0;
         clear_at_end_q <= 1'b0;
         wr_done_q      <= 1'b0;
      end else begin
         if (cs_fall) begin
            clear_at_end_q <= 1'b0;
            wr_done_q      <= 1'b0;
         end
         if (byte_done && state_q == SSWP_OPCODE) begin
            if (rx_byte == OP_LATCH_SET) latch_q <= 1'b1;
            if (rx_byte == OP_LATCH_CLEAR) clear_at_end_q <= 1'b1;
            if (is_write_class(rx_byte) && rx_byte != OP_STATUS_WRITE && latch_q)
               wr_done_q <= 1'b1;
         end
         if (byte_done && state_q == SSWP_DATA) wr_done_q <= 1'b1;
         if (cs_rise && (clear_at_end_q || wr_done_q)) latch_q <= 1'b0;
      end
   end

   // output byte: loaded at send entry, shifted on sclk fall
   always_ff @(posedge aclk) begin
      if (!aresetn) out_q <= 8'h00;
      else if (byte_done && (state_q == SSWP_SEND ||
               (state_q == SSWP_OPCODE && rx_byte == OP_STATUS_READ) ||
               state_q == SSWP_DUMMY)) out_q <= status_rd;
      else if (sclk_fall && state_q == SSWP_SEND && bit_q != 3'd0) out_q <= {out_q[6:0], 1'b0};
   end

   // miso from flip-flop, driven only while sending
   logic miso_q, miso_oe_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         miso_q    <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_oe_q <= state_q == SSWP_SEND && !cs_f;
         miso_q    <= out_q[7];
      end
   end
   assign link.miso    = miso_q;
   assign link.miso_oe = miso_oe_q;

   // array protection and serial lock to the rest of the chip
   assign check_protected = sswp_addr_protected(sel_q, check_addr);
   assign serial_write_ok = ~lock_q & latch_q;
   // nonvolatile copy taken only on a completed save
   always_ff @(posedge aclk) begin
      if (!aresetn) nv_status_out <= STATUS_RESET;
      else if (save_done) nv_status_out <= status_rd & STATUS_WR_MASK;
   end
endmodule // sswp_device

// [hw/sswp_host.sv]
// spi host controller end, driven from software over axi4-lite
// assumes a single device on the link and mode 0 clocking
`timescale 1ns/1ps
module sswp_host
   import sswp_pkg::*;
#(
   parameter int DIV = HOST_DIV
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   sswp_link_if.host        link
);
   // ------------------------------------------------------------
   // axi write side: address and data taken in either order
   // ------------------------------------------------------------
   logic       aw_q, w_q, busy_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic       go;
   assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (aw_q && w_q) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == REG_CMD || awaddr_q == REG_RESULT) ? RESP_OKAY
                           : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
   end
   // a go while busy is dropped, software polls busy first
   assign go = aw_q && w_q && awaddr_q == REG_CMD && wdata_q[16] && !busy_q &&
               s_axi_wstrb != 4'h0;

   // ------------------------------------------------------------
   // spi engine: cs fall, opcode, optional dummy and data, cs rise
   // ------------------------------------------------------------
   logic [7:0]  op_q, rx_q, result_q;
   logic [4:0]  nbits_q, cnt_q;
   logic [15:0] div_q;
   logic        sclk_q, cs_n_q, mosi_q;
   logic [15:0] tx_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         mosi_q <= 1'b0;
         tx_q <= 16'h0;
         cnt_q <= 5'd0;
         nbits_q <= 5'd0;
         div_q <= 16'h0;
         op_q <= 8'h00;
         rx_q <= 8'h00;
         result_q <= 8'h00;
      end else if (go) begin
         busy_q <= 1'b1;
         cs_n_q <= 1'b0;
         op_q <= wdata_q[7:0];
         // opcode then a second byte for read, fast read (dummy) and write
         tx_q <= {wdata_q[7:0], wdata_q[15:8]};
         nbits_q <= (wdata_q[7:0] == OP_STATUS_FASTREAD) ? 5'd24 :
                    (wdata_q[7:0] inside {OP_STATUS_READ, OP_STATUS_WRITE}) ? 5'd16 : 5'd8;
         mosi_q <= wdata_q[7];
         cnt_q <= 5'd0;
         div_q <= 16'h0;
      end else if (busy_q) begin
         div_q <= div_q + 16'h1;
         if (div_q == 16'(DIV - 1)) begin
            div_q <= 16'h0;
            if (cnt_q == nbits_q) begin
               cs_n_q <= 1'b1;  // ends the frame
               busy_q <= 1'b0;
               result_q <= rx_q;
            end else if (!sclk_q) begin
               sclk_q <= 1'b1;
            end else begin
               // miso taken at the end of the high phase: the far end's
               // filtered edge detect needs five aclk cycles, more than a half period, to answer
               sclk_q <= 1'b0;
               rx_q <= {rx_q[6:0], link.miso};
               cnt_q <= cnt_q + 5'd1;
               tx_q <= {tx_q[14:0], 1'b0};
               mosi_q <= tx_q[14];
            end
         end
      end
   end
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = mosi_q;

   // ------------------------------------------------------------
   // axi read side
   // ------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         if (s_axi_araddr == REG_CMD) s_axi_rdata <= {24'h0, op_q};
         else if (s_axi_araddr == REG_RESULT) s_axi_rdata <= {23'h0, busy_q, result_q};
         else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
   end
endmodule // sswp_host

// [hw/sswp_link_if.sv]
// spi link between the host controller and the status block
// assumes mode 0: data changes on sclk fall, sampled on rise
`timescale 1ns/1ps
interface sswp_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
   modport host   (output sclk, output cs_n, output mosi, input miso, input miso_oe);
endinterface // sswp_link_if

// [hw/sswp_pkg.sv]
// package for the status register and write-protect block of a serial nvram
// assumes both ends share this package and an spi mode 0 link
package sswp_pkg;
   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_STATUS_READ     = 8'h05;
   localparam logic [7:0] OP_STATUS_FASTREAD = 8'h09;
   localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
   localparam logic [7:0] OP_LATCH_SET       = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR     = 8'h04;
   localparam logic [7:0] OP_MEM_READ        = 8'h03;
   localparam logic [7:0] OP_MEM_WRITE       = 8'h02;
   localparam logic [7:0] OP_CLOCK_WRITE     = 8'h12;
   localparam logic [7:0] OP_SAVE            = 8'h3C;
   localparam logic [7:0] OP_RESTORE         = 8'h60;
   localparam logic [7:0] OP_AUTOSAVE_ON     = 8'h59;
   localparam logic [7:0] OP_AUTOSAVE_OFF    = 8'h19;
   localparam logic [7:0] OP_SERIAL_WRITE    = 8'hC2;
   // ------------------------------------------------------------
   // status field positions and reset value
   // ------------------------------------------------------------
   localparam int         BIT_BUSY      = 0;
   localparam int         BIT_LATCH     = 1;
   localparam int         BIT_SEL_LO    = 2;
   localparam int         BIT_SEL_HI    = 3;
   localparam int         BIT_LOCK      = 6;
   localparam int         BIT_PIN_GUARD = 7;
   localparam logic [7:0] STATUS_WR_MASK = 8'hCC;
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   // ------------------------------------------------------------
   // protected address starts, 15-bit array
   // ------------------------------------------------------------
   localparam logic [14:0] PROT_START_QTR = 15'h6000;
   localparam logic [14:0] PROT_START_HALF = 15'h4000;
   localparam logic [14:0] PROT_START_ALL = 15'h0000;
   // ------------------------------------------------------------
   // host axi4-lite register map (byte offsets)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CMD    = 8'h00;  // [7:0] opcode, [15:8] data byte, [16] go
   localparam logic [7:0] REG_RESULT = 8'h04;  // [7:0] byte read back, [8] busy
   localparam int         HOST_DIV   = 4;      // sclk half period in aclk cycles
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // protection test on an array address
   function automatic logic sswp_addr_protected(input logic [1:0] sel, input logic [14:0] a);
      case (sel)
         2'b01:   return a >= PROT_START_QTR;
         2'b10:   return a >= PROT_START_HALF;
         2'b11:   return a >= PROT_START_ALL;
         default: return 1'b0;
      endcase
   endfunction
endpackage
